// File: design/dsm_pkg.sv
package dsm_pkg;

   //------------------------------------------------------------
   // request sequencer states
   //------------------------------------------------------------
   typedef enum logic [2:0] {
      DSM_IDLE = 3'h0,                // no request on the bus
      DSM_REQ  = 3'h1,                // request presented
      DSM_GAP  = 3'h3,                // forced low cycle after ack
      DSM_ABRT = 3'h5,                // abort raised with request
      DSM_HALT = 3'h4                 // parked until reset ends
   } dsm_state_e;

   //------------------------------------------------------------
   // widths and counts
   //------------------------------------------------------------
   localparam int unsigned ADDR_W   = 32;
   localparam int unsigned DATA_W   = 64;
   localparam int unsigned BE_W     = 8;
   localparam int unsigned LINE_W   = 256;
   localparam logic [3:0] BEATS_DW  = 4'h4;   // 64-bit slave line
   localparam logic [3:0] BEATS_WD  = 4'h8;   // 32-bit slave line
   localparam logic [3:0] BEATS_ONE = 4'h1;   // single word
   localparam logic [1:0] RD_MAX    = 2'h2;   // reads outstanding
   localparam logic [1:0] WR_GAP    = 2'h2;   // idle after last write

   //------------------------------------------------------------
   // values after reset
   //------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 64'h0000_0000_0000_0000;

   //------------------------------------------------------------
   // beats a transfer needs
   //------------------------------------------------------------
   function automatic logic [3:0] beats_of(input logic line,
                                           input logic w64);
      beats_of = !line ? BEATS_ONE : (w64 ? BEATS_DW : BEATS_WD);
   endfunction : beats_of

endpackage : dsm_pkg

// File: design/dsm_port.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] request held until slave acknowledges address
// [R2] request drops cycle after acknowledge
// [R3] slave latches qualifiers by ack cycle
// [R4] qualifiers stable until cycle after ack
// [R5] byte enables valid for single words
// [R6] two-bit priority valid with request
// [R7] at most two reads, one write
// [R8] request low one cycle between requests
// [R9] slave serves requests in issue order
// [R10] writes wait two cycles after last ack
// [R11] abort only on processor reset
// [R12] read/write flag high for reads
// [R13] size flag high for line transfers
// [R14] line selected by upper address bits
// [R15] line is four or eight beats
// [R16] read beats tagged with word index
// [R17] single word moves up to four bytes
// [R18] 32-bit address, separate 64-bit buses
// [R19] slave acknowledges read and write data
// [R20] slave reports busy and error
// [R21] four storage attributes with request
// [R22] unused slave inputs held at zero
// [R23] cacheable high means cacheable data
// [R24] write-through meaningful only when cacheable
// [R25] slave never touches guarded storage speculatively
// [R26] request and abort low during reset
module dsm_port (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   input  wire logic                 proc_reset,
   // request from the cache unit
   input  wire logic                 core_req_valid,
   output logic                      core_req_ready,
   input  wire logic                 core_req_read,
   input  wire logic                 core_req_line,
   input  wire logic [31:0]          core_req_addr,
   input  wire logic [7:0]           core_req_be,
   input  wire logic                 core_req_cacheable,
   input  wire logic                 core_req_write_through,
   input  wire logic                 core_req_user,
   input  wire logic                 core_req_guarded,
   input  wire logic [1:0]           core_req_prio,
   input  wire logic [255:0]         core_req_wdata,
   // returns to the cache unit
   output logic                      core_rd_valid,
   output logic [63:0]               core_rd_data,
   output logic [2:0]                core_rd_index,
   output logic                      core_wr_done,
   output logic                      core_bus_error,
   output logic                      core_slave_busy,
   // request to the bus
   output logic                      dside_req,
   output logic                      dside_read_not_write,
   output logic [31:0]               dside_addr_bus,
   output logic                      dside_line_size,
   output logic                      dside_attr_cacheable,
   output logic                      dside_attr_write_through,
   output logic                      dside_attr_user,
   output logic                      dside_attr_guarded,
   output logic [7:0]                dside_byte_en,
   output logic [1:0]                dside_req_priority,
   output logic                      dside_abort,
   output logic [63:0]               dside_wr_data,
   // answers from the slave
   input  wire logic                 slv_addr_ack,
   input  wire logic                 slv_width_64,
   input  wire logic                 slv_rd_data_ack,
   input  wire logic [63:0]          slv_rd_data,
   input  wire logic [2:0]           slv_rd_word_index,
   input  wire logic                 slv_wr_data_ack,
   input  wire logic                 slv_busy,
   input  wire logic                 slv_error
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      dsm_pkg::dsm_state_e st;
      logic                rnw;
      logic                line;
      logic [31:0]         addr;
      logic [7:0]          be;
      logic                cach;
      logic                wt;
      logic                user;
      logic                grd;
      logic [1:0]          prio;
      logic [3:0][63:0]    wbuf;
      logic [63:0]         wdata;
      logic [1:0]          rd_cnt;
      logic [3:0]          rq0;
      logic [3:0]          rq1;
      logic                wr_out;
      logic                wr_w64;
      logic [3:0]          wr_left;
      logic [2:0]          wr_idx;
      logic [1:0]          wgap;
      logic                rd_valid;
      logic [63:0]         rd_data;
      logic [2:0]          rd_idx;
      logic                wr_done;
      logic                err;
      logic                busy;
   } dsm_state_s;

   dsm_state_s q, d;

   // write beat k: doubleword, or word k copied into both lanes for 32-bit
   function automatic logic [63:0] wr_beat(input logic [3:0][63:0] b,
                                           input logic [2:0] idx,
                                           input logic w64);
      logic [63:0] dw;
      dw = b[idx[2:1]];
      if (w64) begin
         wr_beat = b[idx[1:0]];
      end else if (idx[0]) begin
         wr_beat = {dw[31:0], dw[31:0]};
      end else begin
         wr_beat = {dw[63:32], dw[63:32]};
      end
   endfunction : wr_beat

   logic       in_req;
   logic       take_ack;
   logic [3:0] beats_now;
   logic       can_read;
   logic       can_write;
   logic       wo_cur;
   logic [3:0] wl_cur;
   logic [2:0] wi_cur;
   logic       w64_cur;

   //------------------------------------------------------------
   // acceptance of a core request
   //------------------------------------------------------------
   assign in_req    = (q.st == dsm_pkg::DSM_REQ) ||
                      (q.st == dsm_pkg::DSM_ABRT);
   assign take_ack  = in_req && slv_addr_ack;             // [R1]
   assign beats_now = dsm_pkg::beats_of(q.line, slv_width_64); // [R15]
   assign can_read  = q.rd_cnt < dsm_pkg::RD_MAX;         // [R7]
   assign can_write = !q.wr_out && (q.wgap == 2'h0);      // [R10]
   assign core_req_ready = ((q.st == dsm_pkg::DSM_IDLE) ||
                            (q.st == dsm_pkg::DSM_GAP)) && // [R8]
                           !proc_reset &&
                           (core_req_read ? can_read : can_write);

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      d = q;
      d.rd_valid = slv_rd_data_ack;                       // [R19]
      d.rd_data  = slv_rd_data;
      d.rd_idx   = slv_rd_word_index;                     // [R16]
      d.err      = slv_error;                             // [R20]
      d.busy     = slv_busy;
      d.wr_done  = 1'b0;
      if (q.wgap != 2'h0) begin
         d.wgap = q.wgap - 2'h1;
      end
      // read beats retire the oldest read first
      if (slv_rd_data_ack && (q.rd_cnt != 2'h0)) begin    // [R9]
         if (q.rq0 == 4'h1) begin
            d.rq0    = q.rq1;
            d.rq1    = 4'h0;
            d.rd_cnt = q.rd_cnt - 2'h1;
         end else begin
            d.rq0 = q.rq0 - 4'h1;
         end
      end
      // an acknowledged read joins the queue behind the others
      if (take_ack && q.rnw) begin
         if (d.rd_cnt == 2'h0) begin
            d.rq0 = beats_now;
         end else begin
            d.rq1 = beats_now;
         end
         d.rd_cnt = d.rd_cnt + 2'h1;
      end
      // write tracking, allowing data ack in the address ack cycle
      wo_cur  = q.wr_out;
      wl_cur  = q.wr_left;
      wi_cur  = q.wr_idx;
      w64_cur = q.wr_w64;
      if (take_ack && !q.rnw) begin
         wo_cur  = 1'b1;
         wl_cur  = beats_now;                             // [R15]
         wi_cur  = 3'h0;
         w64_cur = slv_width_64;
      end
      d.wr_out  = wo_cur;
      d.wr_left = wl_cur;
      d.wr_idx  = wi_cur;
      d.wr_w64  = w64_cur;
      d.wdata   = wr_beat(q.wbuf, wi_cur, w64_cur);
      if (slv_wr_data_ack && wo_cur) begin                // [R19]
         d.wr_idx = wi_cur + 3'h1;
         d.wdata  = wr_beat(q.wbuf, wi_cur + 3'h1, w64_cur);
         if (wl_cur == 4'h1) begin
            d.wr_out  = 1'b0;
            d.wr_done = 1'b1;
            d.wgap    = dsm_pkg::WR_GAP;                  // [R10]
         end else begin
            d.wr_left = wl_cur - 4'h1;
         end
      end
      // request sequencer
      case (q.st)
         dsm_pkg::DSM_REQ: begin
            if (slv_addr_ack) begin
               d.st = dsm_pkg::DSM_GAP;                   // [R2]
            end else if (proc_reset) begin
               d.st = dsm_pkg::DSM_ABRT;                  // [R11]
            end
         end
         dsm_pkg::DSM_ABRT: begin
            d.st = dsm_pkg::DSM_HALT;                     // [R11]
         end
         dsm_pkg::DSM_HALT: begin
            if (!proc_reset) begin
               d.st = dsm_pkg::DSM_IDLE;
            end
         end
         default: begin
            if (core_req_valid && core_req_ready) begin
               d.st    = dsm_pkg::DSM_REQ;
               d.rnw   = core_req_read;                   // [R12]
               d.line  = core_req_line;                   // [R13]
               d.addr  = core_req_addr;                   // [R14]
               d.be    = core_req_be;                     // [R5]
               d.cach  = core_req_cacheable;              // [R23]
               d.wt    = core_req_write_through;          // [R24]
               d.user  = core_req_user;                   // [R21]
               d.grd   = core_req_guarded;
               d.prio  = core_req_prio;                   // [R6]
               if (!core_req_read) begin
                  d.wbuf  = core_req_wdata;
                  d.wdata = core_req_wdata[63:0];
               end
            end else begin
               d.st = dsm_pkg::DSM_IDLE;
            end
         end
      endcase
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;                                         // [R26]
      end else begin
         q <= d;
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   assign dside_req                = in_req;             // [R1]
   assign dside_abort              = q.st == dsm_pkg::DSM_ABRT;
   assign dside_read_not_write     = q.rnw;               // [R4]
   assign dside_addr_bus           = q.addr;              // [R18]
   assign dside_line_size          = q.line;
   assign dside_attr_cacheable     = q.cach;
   assign dside_attr_write_through = q.wt;
   assign dside_attr_user          = q.user;
   assign dside_attr_guarded       = q.grd;
   assign dside_byte_en            = q.be;                // [R17]
   assign dside_req_priority       = q.prio;
   assign dside_wr_data            = q.wdata;
   assign core_rd_valid            = q.rd_valid;
   assign core_rd_data             = q.rd_data;
   assign core_rd_index            = q.rd_idx;
   assign core_wr_done             = q.wr_done;
   assign core_bus_error           = q.err;
   assign core_slave_busy          = q.busy;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   logic [1:0] since_wr;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         since_wr <= 2'h3;
      end else if (q.wr_done) begin
         since_wr <= 2'h0;
      end else if (since_wr != 2'h3) begin
         since_wr <= since_wr + 2'h1;
      end
   end

   sequence s_take;
      core_req_valid && core_req_ready;
   endsequence
   sequence s_abort_drop;
      dside_abort && dside_req ##1 !dside_req;
   endsequence

   req_drop_a: assert property (dside_req && slv_addr_ack |=> // [R2]
         !dside_req) else $error("request held after ack");
   qual_hold_a: assert property (dside_req && !slv_addr_ack |=> // [R4]
         $stable(dside_addr_bus) && $stable(dside_read_not_write) &&
         $stable(dside_byte_en) && $stable(dside_line_size))
      else $error("qualifiers changed before ack");
   rd_limit_a: assert property ($rose(dside_req) && // [R7]
         dside_read_not_write |-> $past(q.rd_cnt) < 2'h2)
      else $error("third read issued");
   wr_space_a: assert property ($rose(dside_req) && // [R10]
         !dside_read_not_write |-> since_wr >= 2'h2 && !q.wr_out)
      else $error("write issued too soon");
   abort_seq_a: assert property (dside_abort |-> s_abort_drop // [R11]
         ##0 !dside_abort)
      else $error("abort did not drop request");
   abort_cause_a: assert property ($rose(dside_abort) |-> // [R11]
         $past(proc_reset)) else $error("abort without reset");
   take_fields_a: assert property (s_take |=> dside_req && // [R12]
         dside_read_not_write == $past(core_req_read) &&
         dside_line_size == $past(core_req_line) &&        // [R13]
         dside_byte_en == $past(core_req_be))               // [R5]
      else $error("request fields not loaded");
   take_attr_a: assert property (s_take |=> // [R21]
         dside_req_priority == $past(core_req_prio) &&      // [R6]
         dside_attr_cacheable == $past(core_req_cacheable) &&
         dside_attr_guarded == $past(core_req_guarded))
      else $error("attributes not loaded");
   gap_low_a: assert property ($fell(dside_req) |-> // [R2]
         $past(slv_addr_ack) || $past(dside_abort))
      else $error("request dropped without ack or abort");

endmodule : dsm_port

`default_nettype wire

// File: verification/dsm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// bus slave and arbiter stand-in
//------------------------------------------------------------
module dsm_slave_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // behaviour controls
   input  wire logic        w64_mode,
   input  wire logic [3:0]  ack_wait,
   input  wire logic        slow,
   // request from the port
   input  wire logic        dside_req,
   input  wire logic        dside_read_not_write,
   input  wire logic        dside_line_size,
   input  wire logic        dside_abort,
   // answers to the port
   output logic             slv_addr_ack,
   output logic             slv_width_64,
   output logic             slv_rd_data_ack,
   output logic [63:0]      slv_rd_data,
   output logic [2:0]       slv_rd_word_index,
   output logic             slv_wr_data_ack,
   output logic             slv_busy,
   output logic             slv_error
);
   int   q_rnw[$];
   int   q_n[$];
   int   beat, seq, wcnt, idx;
   logic stall;

   // data beats first, so a new transfer starts no sooner than a cycle after its ack
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         slv_addr_ack      <= 1'b0;
         slv_width_64      <= 1'b0;
         slv_rd_data_ack   <= 1'b0;
         slv_rd_data       <= 64'h0;
         slv_rd_word_index <= 3'h0;
         slv_wr_data_ack   <= 1'b0;
         slv_busy          <= 1'b0;
         slv_error         <= 1'b0;
         q_rnw.delete();
         q_n.delete();
         beat = 0;
         seq = 0;
         wcnt = 0;
         stall = 1'b0;
      end else begin
         slv_addr_ack      <= 1'b0;
         slv_rd_data_ack   <= 1'b0;
         slv_wr_data_ack   <= 1'b0;
         slv_width_64      <= ~w64_mode;          // only valid with ack
         slv_rd_data       <= ~slv_rd_data;       // released bus wanders
         slv_rd_word_index <= ~slv_rd_word_index;
         // strictly in issue order, whole transfer before the next
         if (q_n.size() > 0 && !(slow && stall)) begin
            if (q_rnw[0] != 0) begin
               idx = (q_n[0] == 1) ? 0 : q_n[0] - 1 - beat;
               slv_rd_data_ack   <= 1'b1;
               slv_rd_data       <= {32'hd0d0_0000 + 32'(seq), 32'(idx)};
               slv_rd_word_index <= idx[2:0];
            end else begin
               slv_wr_data_ack <= 1'b1;
            end
            beat++;
            if (beat == q_n[0]) begin
               if (q_rnw[0] != 0) seq++;
               beat = 0;
               void'(q_rnw.pop_front());
               void'(q_n.pop_front());
            end
         end
         stall = ~stall;
         // address acceptance after a programmable wait
         if (!dside_req || dside_abort) begin
            wcnt = 0;
         end else if (!slv_addr_ack) begin
            if (wcnt >= int'(ack_wait)) begin
               slv_addr_ack <= 1'b1;
               slv_width_64 <= w64_mode;
               q_rnw.push_back(int'(dside_read_not_write));
               q_n.push_back(!dside_line_size ? 1 : (w64_mode ? 4 : 8));
               wcnt = 0;
            end else begin
               wcnt++;
            end
         end
         slv_busy <= (q_n.size() != 0);
         slv_error <= (q_n.size() != 0) && stall;
      end
   end
endmodule : dsm_slave_model
`default_nettype wire

// File: verification/dsm_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// testbench top
//------------------------------------------------------------
module dsm_port_tb_top;
   logic clk_sys, arst_n, proc_reset, core_req_valid, core_req_ready;
   logic core_req_read, core_req_line, core_req_cacheable, core_req_user;
   logic core_req_write_through, core_req_guarded, core_rd_valid;
   logic core_wr_done, core_bus_error, core_slave_busy, slow, w64_mode;
   logic [31:0] core_req_addr;
   logic [7:0] core_req_be;
   logic [1:0] core_req_prio;
   logic [255:0] core_req_wdata;
   logic [63:0] core_rd_data, dside_wr_data, slv_rd_data;
   logic [2:0] core_rd_index, slv_rd_word_index;
   logic [3:0] ack_wait;
   logic dside_req, dside_read_not_write, dside_line_size, dside_abort;
   logic dside_attr_cacheable, dside_attr_write_through, dside_attr_user;
   logic dside_attr_guarded, slv_addr_ack, slv_width_64, slv_rd_data_ack;
   logic slv_wr_data_ack, slv_busy, slv_error, prev_ack, prev_req;
   logic prev_err, prev_busy;
   logic [31:0] dside_addr_bus;
   logic [7:0] dside_byte_en;
   logic [1:0] dside_req_priority;
   logic [63:0] exp_rd[$];
   logic [63:0] exp_wr[$];
   logic [47:0] exp_q[$];
   logic [2:0] exp_ix[$];
   int failures, total_checks, rd_seq, done_exp, done_seen;
   int cyc, last_ack, last_wack, t;

   dsm_port dut (.clk_sys(clk_sys), .arst_n(arst_n), .proc_reset(proc_reset),
      .core_req_valid(core_req_valid), .core_req_ready(core_req_ready),
      .core_req_read(core_req_read), .core_req_line(core_req_line),
      .core_req_addr(core_req_addr), .core_req_be(core_req_be),
      .core_req_cacheable(core_req_cacheable), .core_req_user(core_req_user),
      .core_req_write_through(core_req_write_through),
      .core_req_guarded(core_req_guarded), .core_req_prio(core_req_prio),
      .core_req_wdata(core_req_wdata), .core_rd_valid(core_rd_valid),
      .core_rd_data(core_rd_data), .core_rd_index(core_rd_index),
      .core_wr_done(core_wr_done), .core_bus_error(core_bus_error),
      .core_slave_busy(core_slave_busy), .dside_req(dside_req),
      .dside_read_not_write(dside_read_not_write),
      .dside_addr_bus(dside_addr_bus), .dside_line_size(dside_line_size),
      .dside_attr_cacheable(dside_attr_cacheable),
      .dside_attr_write_through(dside_attr_write_through),
      .dside_attr_user(dside_attr_user),
      .dside_attr_guarded(dside_attr_guarded), .dside_byte_en(dside_byte_en),
      .dside_req_priority(dside_req_priority), .dside_abort(dside_abort),
      .dside_wr_data(dside_wr_data), .slv_addr_ack(slv_addr_ack),
      .slv_width_64(slv_width_64), .slv_rd_data_ack(slv_rd_data_ack),
      .slv_rd_data(slv_rd_data), .slv_rd_word_index(slv_rd_word_index),
      .slv_wr_data_ack(slv_wr_data_ack), .slv_busy(slv_busy),
      .slv_error(slv_error));

   dsm_slave_model slave (.clk_sys(clk_sys), .arst_n(arst_n),
      .w64_mode(w64_mode), .ack_wait(ack_wait), .slow(slow),
      .dside_req(dside_req), .dside_read_not_write(dside_read_not_write),
      .dside_line_size(dside_line_size), .dside_abort(dside_abort),
      .slv_addr_ack(slv_addr_ack), .slv_width_64(slv_width_64),
      .slv_rd_data_ack(slv_rd_data_ack), .slv_rd_data(slv_rd_data),
      .slv_rd_word_index(slv_rd_word_index),
      .slv_wr_data_ack(slv_wr_data_ack), .slv_busy(slv_busy),
      .slv_error(slv_error));

   // compare one value, count and report
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // verdict and end of run
   task automatic report_and_stop;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // hand one request to the port, record what must come back
   task automatic issue(input logic rd, input logic line);
      int n, k;
      logic [31:0] w;
      n = line ? (w64_mode ? 4 : 8) : 1;
      core_req_read = rd;
      core_req_line = line;
      core_req_addr = $urandom();
      core_req_be = 8'h80 >> ($urandom() % 8);
      {core_req_cacheable, core_req_write_through} = 2'($urandom());
      {core_req_user, core_req_guarded, core_req_prio} = 4'($urandom());
      for (k = 0; k < 8; k++) core_req_wdata[32*k +: 32] = $urandom();
      exp_q.push_back({rd, line, core_req_addr, line ? 8'h00 : core_req_be,
         core_req_cacheable, core_req_write_through, core_req_user,
         core_req_guarded, core_req_prio});
      for (k = 0; k < n; k++) begin
         if (rd) begin
            w = line ? 32'(n - 1 - k) : 32'h0;
            exp_rd.push_back({32'hd0d0_0000 + 32'(rd_seq), w});
            exp_ix.push_back(w[2:0]);
         end else if (w64_mode) begin
            exp_wr.push_back(core_req_wdata[64*k +: 64]);
         end else begin
            w = core_req_wdata[64*(k/2) + 32*(1 - k%2) +: 32];
            exp_wr.push_back({w, w});
         end
      end
      if (rd) rd_seq++;
      else done_exp++;
      core_req_valid = 1'b1;
      #1;
      for (t = 0; t < 300 && !core_req_ready; t++) @(negedge clk_sys);
      @(negedge clk_sys);
      core_req_valid = 1'b0;
      @(negedge clk_sys);
   endtask : issue

   // wait until every expected beat has been seen
   task automatic drain;
      for (t = 0; t < 2000 && exp_rd.size() + exp_wr.size() > 0; t++)
         @(negedge clk_sys);
      repeat (6) @(negedge clk_sys);
      chk(64'(done_seen), 64'(done_exp));
      chk(64'(exp_q.size()), 64'h0);
   endtask : drain

   // bus monitor and reference comparison
   always @(posedge clk_sys) begin
      if (arst_n && !proc_reset) begin
         cyc++;
         if (prev_ack) chk(dside_req, 1'b0);
         if (dside_req && !prev_req) begin
            chk(cyc - last_ack > 1, 1'b1);
            if (!dside_read_not_write) chk(cyc - last_wack > 2, 1'b1);
         end
         if (dside_req && exp_q.size() > 0)
            chk({dside_read_not_write, dside_line_size, dside_addr_bus,
               dside_line_size ? 8'h00 : dside_byte_en, dside_attr_cacheable,
               dside_attr_write_through, dside_attr_user, dside_attr_guarded,
               dside_req_priority}, exp_q[0]);
         prev_ack = dside_req && slv_addr_ack;
         prev_req = dside_req;
         if (prev_ack) begin
            last_ack = cyc;
            void'(exp_q.pop_front());
         end
         if (slv_wr_data_ack) begin
            last_wack = cyc;
            chk(dside_wr_data, exp_wr.pop_front());
         end
         if (core_rd_valid) begin
            chk(core_rd_data, exp_rd.pop_front());
            chk(core_rd_index, exp_ix.pop_front());
         end
         if (core_wr_done) done_seen++;
         chk({core_bus_error, core_slave_busy}, {prev_err, prev_busy});
      end
      {prev_err, prev_busy} = {slv_error, slv_busy};
   end

   // 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // hang guard
   initial begin
      #(25 * 30000);
      failures++;
      report_and_stop();
   end

   // main sequence
   initial begin
      {arst_n, proc_reset, core_req_valid, core_req_read, core_req_line} = 0;
      {core_req_cacheable, core_req_write_through, core_req_user} = 0;
      {core_req_guarded, core_req_prio, core_req_addr, core_req_be} = 0;
      {core_req_wdata, slow, w64_mode, ack_wait} = 0;
      {prev_ack, prev_req, failures, total_checks, rd_seq} = 0;
      {prev_err, prev_busy} = 2'h0;
      {done_exp, done_seen, cyc} = 0;
      last_ack = -10;
      last_wack = -10;
      void'($urandom(32'ha5f340b6));
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n = 1'b1;
      // mixed traffic against a wide prompt slave, then narrow slow one
      for (int m = 1; m >= 0; m--) begin
         w64_mode = m[0];
         ack_wait = m[0] ? 4'h0 : 4'h3;
         slow = !m[0];
         for (int i = 0; i < 8; i++)
            issue(1'(8'b1100_1011 >> i),
               1'(8'b1010_0110 >> i));
         drain();
         $display("test traffic width64=%0d done", m);
      end
      // processor reset while a request waits for its ack
      ack_wait = 4'hf;
      issue(1'b1, 1'b1);
      proc_reset = 1'b1;
      exp_rd.delete();
      exp_ix.delete();
      @(negedge clk_sys);
      chk({dside_abort, dside_req}, 2'b11);
      @(negedge clk_sys);
      chk({dside_abort, dside_req}, 2'b00);
      repeat (3) @(negedge clk_sys);
      chk({dside_abort, dside_req, core_req_ready}, 3'b000);
      exp_q.delete();
      ack_wait = 4'h0;
      proc_reset = 1'b0;
      repeat (20) @(negedge clk_sys);
      rd_seq--;
      issue(1'b1, 1'b0);
      drain();
      $display("test abort done");
      report_and_stop();
   end
endmodule : dsm_port_tb_top
`default_nettype wire
